/* inc/bfs_defs.svh */
// Constants for the two-direction FIFO pair with port B bus sizing
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH

`define BFS_DEPTH        32
`define BFS_AE_LEVEL     8
`define BFS_AF_LEVEL     8
`define BFS_LONG_BITS    36
`define BFS_BYTE_BITS    9
`define BFS_WORD_BITS    18

// Port B width codes {width_sel1, width_sel0}
`define BFS_SIZ_LONG     2'h0
`define BFS_SIZ_BYTE     2'h1
`define BFS_SIZ_WORD     2'h2
`define BFS_SIZ_MAIL     2'h3

// Last piece index of a long word per width
`define BFS_LAST_LONG    2'h0
`define BFS_LAST_WORD    2'h1
`define BFS_LAST_BYTE    2'h3

// Swap codes {swap_sel1, swap_sel0}
`define BFS_SWAP_LL      2'h0
`define BFS_SWAP_LH      2'h1
`define BFS_SWAP_HL      2'h2
`define BFS_SWAP_HH      2'h3

// Flag values held in reset
`define BFS_RST_EMPTY_N  1'h0
`define BFS_RST_FULL_N   1'h1

`endif

/* inc/bfs_pkg.sv */
// Types shared by the FIFO pair
package bfs_pkg;

  typedef struct packed {
    logic        cs_n;
    logic        wnr;
    logic        mb;
    logic [35:0] data;
  } bfs_a_pins_s;

  typedef struct packed {
    logic        cs_n;
    logic        wnr;
    logic        mb;
    logic [1:0]  siz;
    logic [1:0]  swap;
    logic        big;
    logic [35:0] data;
  } bfs_b_pins_s;

  typedef struct packed {
    logic empty_n;
    logic almost_empty_n;
    logic full_n;
    logic almost_full_n;
  } bfs_flags_s;

endpackage : bfs_pkg

/* rtl/bfs_top.sv */
// FIFO pair with port B sizing, byte swapping and per-port flags
`timescale 1ns/100ps
`include "bfs_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module bfs_fifo #(
  parameter int WIDTH = `BFS_LONG_BITS,
  parameter int DEPTH = `BFS_DEPTH,
  parameter int PW    = $clog2(DEPTH) + 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             push_valid_i,
  output      logic             push_ready_o,
  input  wire logic [WIDTH-1:0] push_data_i,
  output      logic             pop_valid_o,
  input  wire logic             pop_ready_i,
  output      logic [WIDTH-1:0] pop_data_o,
  output      logic [PW-1:0]    wr_ptr_o,
  output      logic [PW-1:0]    rd_ptr_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp;
  logic [PW-1:0]    rp;
  logic [PW-1:0]    next_wp;
  logic [PW-1:0]    next_rp;
  logic             do_push;
  logic             do_pop;

  assign push_ready_o = (PW'(wp - rp) != PW'(DEPTH));
  assign pop_valid_o  = (wp != rp);
  assign do_push      = push_valid_i & push_ready_o;
  assign do_pop       = pop_ready_i & pop_valid_o;
  assign pop_data_o   = mem[rp[PW-2:0]];
  assign wr_ptr_o     = wp;
  assign rd_ptr_o     = rp;

  always_comb
  begin
    next_wp = do_push ? PW'(wp + 1'b1) : wp;
    next_rp = do_pop ? PW'(rp + 1'b1) : rp;
    if (!rst_n_i)
    begin
      next_wp = '0;
      next_rp = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    wp <= next_wp;
    rp <= next_rp;
    if (do_push)
      mem[wp[PW-2:0]] <= push_data_i;
  end
endmodule : bfs_fifo

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Big-endian byte reads follow swap order top
// - Little-endian byte reads follow swap order bottom
// - Port B empty rises after FIFO1 write
// - Port A empty rises after completed FIFO2 word
// - Port A full rises after FIFO1 word freed
// - Port B full rises after FIFO2 space freed
// - Port B almost-empty rises above FIFO1 threshold
// - Port A almost-empty rises above FIFO2 threshold
// - Port A almost-full rises below FIFO1 threshold
// - Port B almost-full rises below FIFO2 threshold
// - Both width selects low means long word
// - Port B empty falls on last piece
// - Port B full falls on completing piece
// - Port B almost-empty falls on last piece
// - Port A flags timed from final piece
// - FIFO1 write/read select decoding
// - FIFO2 write/read select decoding
// - Unselected byte lanes hold last output data
module bfs_top
  import bfs_pkg::*;
#(
  parameter int DEPTH  = `BFS_DEPTH,
  parameter int AE_LVL = `BFS_AE_LEVEL,
  parameter int AF_LVL = `BFS_AF_LEVEL
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        side_a_clock_i,
  input  wire logic        side_b_clock_i,
  input  wire logic        a_chip_sel_n_i,
  input  wire logic        a_write_not_read_i,
  input  wire logic        a_mailbox_sel_i,
  input  wire logic [35:0] a_data_i,
  output      logic [35:0] a_data_o,
  input  wire logic        b_chip_sel_n_i,
  input  wire logic        b_write_not_read_i,
  input  wire logic        b_mailbox_sel_i,
  input  wire logic        b_width_sel0_i,
  input  wire logic        b_width_sel1_i,
  input  wire logic        swap_sel0_i,
  input  wire logic        swap_sel1_i,
  input  wire logic        b_big_endian_i,
  input  wire logic [35:0] b_data_i,
  output      logic [35:0] b_data_o,
  output      logic        a_empty_n_o,
  output      logic        a_almost_empty_n_o,
  output      logic        a_full_n_o,
  output      logic        a_almost_full_n_o,
  output      logic        b_empty_n_o,
  output      logic        b_almost_empty_n_o,
  output      logic        b_full_n_o,
  output      logic        b_almost_full_n_o
);
  localparam int PW = $clog2(DEPTH) + 1;

  function automatic logic [35:0] bfs_swap(input logic [35:0] w, input logic [1:0] code);
    logic [35:0] r;
    r = w;
    case (code)
      `BFS_SWAP_LH: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
      `BFS_SWAP_HL: r = {w[17:0], w[35:18]};
      `BFS_SWAP_HH: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default:      r = w;
    endcase
    return r;
  endfunction : bfs_swap

  //////////////////////////////////////////////////////////////////////////////
  // Port clock sampling and edge detection
  logic [1:0] ck_raw;
  logic [1:0] edge_p;
  logic [1:0] edge_d;

  assign ck_raw = {side_b_clock_i, side_a_clock_i};

  for (genvar g = 0; g < 2; g++)
  begin : g_ck
    logic [2:0] sync;
    logic       lvl;
    logic       dly;
    logic [2:0] next_sync;
    logic       next_lvl;
    logic       next_dly;

    always_comb
    begin
      next_sync = {sync[1:0], ck_raw[g]};
      next_lvl  = (sync[1] == sync[2]) ? sync[1] : lvl;
      next_dly  = next_lvl & ~lvl;
      if (!rst_n_i)
      begin
        next_sync = '0;
        next_lvl  = 1'b0;
        next_dly  = 1'b0;
      end
    end

    always_ff @(posedge clk_i)
    begin
      sync <= next_sync;
      lvl  <= next_lvl;
      dly  <= next_dly;
    end

    assign edge_p[g] = rst_n_i & (sync[1] == sync[2]) & sync[1] & ~lvl;
    assign edge_d[g] = dly;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling, aligned with the clock path
  bfs_a_pins_s       a_raw;
  bfs_b_pins_s       b_raw;
  bfs_a_pins_s [2:0] a_pipe;
  bfs_b_pins_s [2:0] b_pipe;
  bfs_a_pins_s [2:0] next_a_pipe;
  bfs_b_pins_s [2:0] next_b_pipe;
  bfs_a_pins_s       a_in;
  bfs_b_pins_s       b_in;

  assign a_raw = '{cs_n: a_chip_sel_n_i, wnr: a_write_not_read_i, mb: a_mailbox_sel_i, data: a_data_i};
  assign b_raw = '{cs_n: b_chip_sel_n_i, wnr: b_write_not_read_i, mb: b_mailbox_sel_i,
                   siz: {b_width_sel1_i, b_width_sel0_i}, swap: {swap_sel1_i, swap_sel0_i},
                   big: b_big_endian_i, data: b_data_i};

  always_comb
  begin
    next_a_pipe = {a_pipe[1:0], a_raw};
    next_b_pipe = {b_pipe[1:0], b_raw};
    if (!rst_n_i)
    begin
      next_a_pipe = '0;
      next_b_pipe = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    a_pipe <= next_a_pipe;
    b_pipe <= next_b_pipe;
  end

  assign a_in = a_pipe[2];
  assign b_in = b_pipe[2];

  //////////////////////////////////////////////////////////////////////////////
  // Access decoding
  bfs_flags_s a_flg;
  bfs_flags_s b_flg;
  logic       b_mail;
  logic [1:0] b_last;
  logic       a_wr1;
  logic       a_rd2;
  logic       b_rd1;
  logic       b_wr2;
  logic       f1_push_ready;
  logic       f1_pop_valid;
  logic       f2_push_ready;
  logic       f2_pop_valid;

  assign b_mail = (b_in.siz == `BFS_SIZ_MAIL);
  assign b_last = (b_in.siz == `BFS_SIZ_LONG) ? `BFS_LAST_LONG :
                  (b_in.siz == `BFS_SIZ_WORD) ? `BFS_LAST_WORD : `BFS_LAST_BYTE;

  assign a_wr1 = edge_p[0] & ~a_in.cs_n & a_in.wnr & ~a_in.mb & a_flg.full_n & f1_push_ready;
  assign a_rd2 = edge_p[0] & ~a_in.cs_n & ~a_in.wnr & ~a_in.mb & a_flg.empty_n & f2_pop_valid;
  assign b_rd1 = edge_p[1] & ~b_in.cs_n & ~b_in.wnr & ~b_in.mb & ~b_mail
                 & b_flg.empty_n & f1_pop_valid;
  assign b_wr2 = edge_p[1] & ~b_in.cs_n & b_in.wnr & ~b_in.mb & ~b_mail
                 & b_flg.full_n & f2_push_ready;

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [35:0]   f1_head;
  logic [35:0]   f2_head;
  logic [35:0]   f2_push_data;
  logic          b_rd_done;
  logic          b_wr_done;
  logic [PW-1:0] f1_wp;
  logic [PW-1:0] f1_rp;
  logic [PW-1:0] f2_wp;
  logic [PW-1:0] f2_rp;

  bfs_fifo #(.WIDTH(`BFS_LONG_BITS), .DEPTH(DEPTH), .PW(PW)) u_fifo1 (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .push_valid_i (a_wr1),
    .push_ready_o (f1_push_ready),
    .push_data_i  (a_in.data),
    .pop_valid_o  (f1_pop_valid),
    .pop_ready_i  (b_rd_done),
    .pop_data_o   (f1_head),
    .wr_ptr_o     (f1_wp),
    .rd_ptr_o     (f1_rp)
  );

  bfs_fifo #(.WIDTH(`BFS_LONG_BITS), .DEPTH(DEPTH), .PW(PW)) u_fifo2 (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .push_valid_i (b_wr_done),
    .push_ready_o (f2_push_ready),
    .push_data_i  (f2_push_data),
    .pop_valid_o  (f2_pop_valid),
    .pop_ready_i  (a_rd2),
    .pop_data_o   (f2_head),
    .wr_ptr_o     (f2_wp),
    .rd_ptr_o     (f2_rp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Port B piece sequencing, lane steering and assembly
  logic [1:0]  rd_idx;
  logic [1:0]  wr_idx;
  logic [35:0] asm_word;
  logic [1:0]  next_rd_idx;
  logic [1:0]  next_wr_idx;
  logic [35:0] next_asm;
  logic [35:0] next_b_data;
  logic [35:0] next_a_data;
  logic [35:0] rd_sw;
  logic [1:0]  rd_k;
  logic [1:0]  wr_k;
  logic [8:0]  wr_byte;
  logic [17:0] wr_half;

  assign b_rd_done    = b_rd1 & (rd_idx == b_last);
  assign b_wr_done    = b_wr2 & (wr_idx == b_last);
  assign rd_sw        = bfs_swap(f1_head, b_in.swap);
  assign f2_push_data = bfs_swap(next_asm, b_in.swap);

  always_comb
  begin
    next_rd_idx = rd_idx;
    next_wr_idx = wr_idx;
    next_asm    = asm_word;
    next_b_data = b_data_o;
    next_a_data = a_rd2 ? f2_head : a_data_o;
    rd_k        = b_in.big ? rd_idx : 2'(b_last - rd_idx);
    wr_k        = b_in.big ? wr_idx : 2'(b_last - wr_idx);
    wr_byte     = b_in.big ? b_in.data[35:27] : b_in.data[8:0];
    wr_half     = b_in.big ? b_in.data[35:18] : b_in.data[17:0];
    if (b_rd1)
    begin
      next_rd_idx = b_rd_done ? 2'h0 : 2'(rd_idx + 1'b1);
      case (b_in.siz)
        `BFS_SIZ_WORD:
        begin
          if (b_in.big)
            next_b_data[35:18] = rd_k[0] ? rd_sw[17:0] : rd_sw[35:18];
          else
            next_b_data[17:0]  = rd_k[0] ? rd_sw[17:0] : rd_sw[35:18];
        end
        `BFS_SIZ_BYTE:
        begin
          if (b_in.big)
            next_b_data[35:27] = rd_sw[35 - 9 * rd_k -: 9];
          else
            next_b_data[8:0]   = rd_sw[35 - 9 * rd_k -: 9];
        end
        default: next_b_data = rd_sw;
      endcase
    end
    if (b_wr2)
    begin
      next_wr_idx = b_wr_done ? 2'h0 : 2'(wr_idx + 1'b1);
      case (b_in.siz)
        `BFS_SIZ_WORD:
        begin
          if (wr_k[0])
            next_asm[17:0]  = wr_half;
          else
            next_asm[35:18] = wr_half;
        end
        `BFS_SIZ_BYTE: next_asm[35 - 9 * wr_k -: 9] = wr_byte;
        default:       next_asm = b_in.data;
      endcase
    end
    if (!rst_n_i)
    begin
      next_rd_idx = '0;
      next_wr_idx = '0;
      next_asm    = '0;
      next_b_data = '0;
      next_a_data = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    rd_idx   <= next_rd_idx;
    wr_idx   <= next_wr_idx;
    asm_word <= next_asm;
    b_data_o <= next_b_data;
    a_data_o <= next_a_data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags: far pointer staged on own edge, then compared
  logic [PW-1:0] a_s_rp1;
  logic [PW-1:0] a_s_wp2;
  logic [PW-1:0] b_s_wp1;
  logic [PW-1:0] b_s_rp2;
  logic [PW-1:0] next_a_s_rp1;
  logic [PW-1:0] next_a_s_wp2;
  logic [PW-1:0] next_b_s_wp1;
  logic [PW-1:0] next_b_s_rp2;
  bfs_flags_s    next_a_flg;
  bfs_flags_s    next_b_flg;
  logic [PW-1:0] a_lvl1;
  logic [PW-1:0] a_lvl2;
  logic [PW-1:0] b_lvl1;
  logic [PW-1:0] b_lvl2;

  assign a_lvl1 = PW'(f1_wp - a_s_rp1);
  assign a_lvl2 = PW'(a_s_wp2 - f2_rp);
  assign b_lvl1 = PW'(b_s_wp1 - f1_rp);
  assign b_lvl2 = PW'(f2_wp - b_s_rp2);

  always_comb
  begin
    next_a_s_rp1 = a_s_rp1;
    next_a_s_wp2 = a_s_wp2;
    next_b_s_wp1 = b_s_wp1;
    next_b_s_rp2 = b_s_rp2;
    next_a_flg   = a_flg;
    next_b_flg   = b_flg;
    if (edge_d[0])
    begin
      next_a_s_rp1             = f1_rp;
      next_a_s_wp2             = f2_wp;
      next_a_flg.empty_n       = (a_lvl2 != '0);
      next_a_flg.almost_empty_n = (a_lvl2 > PW'(AE_LVL));
      next_a_flg.full_n        = (a_lvl1 < PW'(DEPTH));
      next_a_flg.almost_full_n = (a_lvl1 < PW'(DEPTH - AF_LVL));
    end
    if (edge_d[1])
    begin
      next_b_s_wp1             = f1_wp;
      next_b_s_rp2             = f2_rp;
      next_b_flg.empty_n       = (b_lvl1 != '0);
      next_b_flg.almost_empty_n = (b_lvl1 > PW'(AE_LVL));
      next_b_flg.full_n        = (b_lvl2 < PW'(DEPTH));
      next_b_flg.almost_full_n = (b_lvl2 < PW'(DEPTH - AF_LVL));
    end
    if (!rst_n_i)
    begin
      next_a_s_rp1 = '0;
      next_a_s_wp2 = '0;
      next_b_s_wp1 = '0;
      next_b_s_rp2 = '0;
      next_a_flg   = '{`BFS_RST_EMPTY_N, `BFS_RST_EMPTY_N, `BFS_RST_FULL_N, `BFS_RST_FULL_N};
      next_b_flg   = '{`BFS_RST_EMPTY_N, `BFS_RST_EMPTY_N, `BFS_RST_FULL_N, `BFS_RST_FULL_N};
    end
  end

  always_ff @(posedge clk_i)
  begin
    a_s_rp1 <= next_a_s_rp1;
    a_s_wp2 <= next_a_s_wp2;
    b_s_wp1 <= next_b_s_wp1;
    b_s_rp2 <= next_b_s_rp2;
    a_flg   <= next_a_flg;
    b_flg   <= next_b_flg;
  end

  assign a_empty_n_o        = a_flg.empty_n;
  assign a_almost_empty_n_o = a_flg.almost_empty_n;
  assign a_full_n_o         = a_flg.full_n;
  assign a_almost_full_n_o  = a_flg.almost_full_n;
  assign b_empty_n_o        = b_flg.empty_n;
  assign b_almost_empty_n_o = b_flg.almost_empty_n;
  assign b_full_n_o         = b_flg.full_n;
  assign b_almost_full_n_o  = b_flg.almost_full_n;
endmodule : bfs_top

/* testbench/bfs_top_properties.sv */
// Port checker for the FIFO pair
`timescale 1ns/100ps

////////////////////////////////////////
module bfs_top_properties (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        side_a_clock_i,
  input wire logic        side_b_clock_i,
  input wire logic        a_chip_sel_n_i,
  input wire logic        a_write_not_read_i,
  input wire logic        a_mailbox_sel_i,
  input wire logic [35:0] a_data_o,
  input wire logic        b_chip_sel_n_i,
  input wire logic        b_write_not_read_i,
  input wire logic        b_mailbox_sel_i,
  input wire logic        b_width_sel0_i,
  input wire logic        b_width_sel1_i,
  input wire logic        b_big_endian_i,
  input wire logic [35:0] b_data_o,
  input wire logic        a_empty_n_o,
  input wire logic        a_almost_empty_n_o,
  input wire logic        a_full_n_o,
  input wire logic        a_almost_full_n_o,
  input wire logic        b_empty_n_o,
  input wire logic        b_almost_empty_n_o,
  input wire logic        b_full_n_o,
  input wire logic        b_almost_full_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [3:0] fa;
  logic [3:0] fb;
  logic [1:0] siz;
  logic       a_rd;
  logic       b_rd;
  assign fa = {a_empty_n_o, a_almost_empty_n_o, a_full_n_o, a_almost_full_n_o};
  assign fb = {b_empty_n_o, b_almost_empty_n_o, b_full_n_o, b_almost_full_n_o};
  assign siz = {b_width_sel1_i, b_width_sel0_i};
  assign a_rd = !a_chip_sel_n_i && !a_write_not_read_i && !a_mailbox_sel_i;
  assign b_rd = !b_chip_sel_n_i && !b_write_not_read_i && !b_mailbox_sel_i && siz != 2'h3;

  AST_RST_FLAGS: assert property ($rose(rst_n_i) |-> fa == 4'h3 && fb == 4'h3)
    else $error("flags wrong after reset");
  AST_A_FLAG_EDGE: assert property ($changed(fa) |-> $past(side_a_clock_i, 5) && !$past(side_a_clock_i, 6))
    else $error("port A flag moved off its clock");
  AST_B_FLAG_EDGE: assert property ($changed(fb) |-> $past(side_b_clock_i, 5) && !$past(side_b_clock_i, 6))
    else $error("port B flag moved off its clock");
  AST_A_READ: assert property ($changed(a_data_o) |-> $past(a_rd, 2) && $past(a_empty_n_o, 2))
    else $error("port A data moved without a read");
  AST_B_READ: assert property ($changed(b_data_o) |-> $past(b_rd, 2) && $past(b_empty_n_o, 2))
    else $error("port B data moved without a read");
  AST_BE_BYTE: assert property ($changed(b_data_o) && siz == 2'h1 && b_big_endian_i |-> $stable(b_data_o[26:0]))
    else $error("big endian byte read touched low lanes");
  AST_LE_BYTE: assert property ($changed(b_data_o) && siz == 2'h1 && !b_big_endian_i |-> $stable(b_data_o[35:9]))
    else $error("little endian byte read touched high lanes");
  AST_BE_WORD: assert property ($changed(b_data_o) && siz == 2'h2 && b_big_endian_i |-> $stable(b_data_o[17:0]))
    else $error("big endian word read touched low half");
  AST_LE_WORD: assert property ($changed(b_data_o) && siz == 2'h2 && !b_big_endian_i |-> $stable(b_data_o[35:18]))
    else $error("little endian word read touched high half");
  AST_A_LEVELS: assert property ((a_empty_n_o || !a_almost_empty_n_o) && (a_full_n_o || !a_almost_full_n_o))
    else $error("port A flags disagree");
  AST_B_LEVELS: assert property ((b_empty_n_o || !b_almost_empty_n_o) && (b_full_n_o || !b_almost_full_n_o))
    else $error("port B flags disagree");

  cover property (!b_empty_n_o ##1 b_empty_n_o);
  cover property ($fell(a_full_n_o));
  cover property ($changed(b_data_o) && siz == 2'h1);
  cover property ($changed(b_data_o) && siz == 2'h2);
endmodule : bfs_top_properties

bind bfs_top bfs_top_properties bfs_top_properties_i (.*);

/* testbench/bfs_host_model.sv */
// Processor model on both ports of the FIFO pair
`timescale 1ns/100ps

////////////////////////////////////////
module bfs_host_model
  import bfs_pkg::*;
#(
  parameter int A_HALF = 5,
  parameter int B_HALF = 6
) (
  input  wire logic  clk_i,
  output logic       a_clk_o,
  output logic       b_clk_o,
  output bfs_a_pins_s a_o,
  output bfs_b_pins_s b_o
);
  int ca = 0;
  int cb = 0;

  initial
  begin
    a_clk_o = 1'b0;
    b_clk_o = 1'b0;
    a_o = '{cs_n: 1'b1, default: '0};
    b_o = '{cs_n: 1'b1, default: '0};
  end

  // Free-running port clocks, unrelated periods
  always @(posedge clk_i)
  begin
    #1;
    ca = (ca + 1) % A_HALF;
    cb = (cb + 1) % B_HALF;
    if (ca == 0) a_clk_o = !a_clk_o;
    if (cb == 0) b_clk_o = !b_clk_o;
  end

  ////////////////////////////////////////
  task automatic a_op(input logic wnr, input logic mb, input logic [35:0] d);
    @(negedge a_clk_o);
    a_o = '{cs_n: 1'b0, wnr: wnr, mb: mb, data: d};
    @(posedge a_clk_o);
    @(negedge a_clk_o);
    a_o.cs_n = 1'b1;
    a_o.data = ~d;
  endtask : a_op

  task automatic b_op(input logic wnr, input logic mb, input logic [1:0] siz, input logic [1:0] sw, input logic big,
                      input logic [35:0] d);
    @(negedge b_clk_o);
    b_o = '{cs_n: 1'b0, wnr: wnr, mb: mb, siz: siz, swap: sw, big: big, data: d};
    @(posedge b_clk_o);
    @(negedge b_clk_o);
    b_o.cs_n = 1'b1;
    b_o.data = ~d;
  endtask : b_op

  task automatic a_wait(input int n);
    repeat (n) @(negedge a_clk_o);
  endtask : a_wait

  task automatic b_wait(input int n);
    repeat (n) @(negedge b_clk_o);
  endtask : b_wait
endmodule : bfs_host_model

/* testbench/bfs_top_test.sv */
// Self-checking bench for the FIFO pair
`timescale 1ns/100ps

////////////////////////////////////////
module bfs_top_test;
  import bfs_pkg::*;

  logic        clk_i;
  logic        rst_n_i;
  logic        a_clk;
  logic        b_clk;
  bfs_a_pins_s ap;
  bfs_b_pins_s bp;
  wire  [35:0] a_data_o;
  wire  [35:0] b_data_o;
  wire  [3:0]  fa;
  wire  [3:0]  fb;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;

  bfs_host_model h (.clk_i(clk_i), .a_clk_o(a_clk), .b_clk_o(b_clk), .a_o(ap), .b_o(bp));

  bfs_top bfs_top_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .side_a_clock_i(a_clk), .side_b_clock_i(b_clk),
    .a_chip_sel_n_i(ap.cs_n), .a_write_not_read_i(ap.wnr), .a_mailbox_sel_i(ap.mb),
    .a_data_i(ap.data), .a_data_o(a_data_o),
    .b_chip_sel_n_i(bp.cs_n), .b_write_not_read_i(bp.wnr), .b_mailbox_sel_i(bp.mb),
    .b_width_sel0_i(bp.siz[0]), .b_width_sel1_i(bp.siz[1]), .swap_sel0_i(bp.swap[0]),
    .swap_sel1_i(bp.swap[1]), .b_big_endian_i(bp.big), .b_data_i(bp.data), .b_data_o(b_data_o),
    .a_empty_n_o(fa[3]), .a_almost_empty_n_o(fa[2]), .a_full_n_o(fa[1]), .a_almost_full_n_o(fa[0]),
    .b_empty_n_o(fb[3]), .b_almost_empty_n_o(fb[2]), .b_full_n_o(fb[1]), .b_almost_full_n_o(fb[0])
  );

  ////////////////////////////////////////
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Flags compared under a mask {empty, almost empty, full, almost full}
  task automatic chkf(input logic [3:0] got, input logic [3:0] exp, input logic [3:0] m, input string what);
    num_checks++;
    if ((got & m) !== (exp & m))
    begin
      mismatches++;
      $display("mismatch at %0t: %s flags %b want %b", $time, what, got, exp);
    end
  endtask : chkf

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  function automatic logic [8:0] lane(input logic [35:0] w, input logic [1:0] sw, input int k);
    logic [1:0] x;
    x = {sw[1] ^ sw[0], sw[0]} ^ 2'(k);
    return w[35 - 9 * x -: 9];
  endfunction : lane

  function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] sw);
    return {lane(w, sw, 0), lane(w, sw, 1), lane(w, sw, 2), lane(w, sw, 3)};
  endfunction : swp

  ////////////////////////////////////////
  task automatic t_reset;
    chkf(fa, 4'h3, 4'hF, "A reset");
    chkf(fb, 4'h3, 4'hF, "B reset");
    chk(a_data_o, 36'h0, "A reset data");
    chk(b_data_o, 36'h0, "B reset data");
  endtask : t_reset

  task automatic t_bytes;
    logic [35:0] w;
    logic [35:0] e;
    for (int big = 0; big < 2; big++)
      for (int sw = 0; sw < 4; sw++)
      begin
        w = 36'h1_2345_6789 + 36'(sw * 2 + big);
        h.a_op(1'b1, 1'b1, w);
        h.b_wait(3);
        chkf(fb, 4'h0, 4'h8, "mailbox write");
        h.a_op(1'b1, 1'b0, w);
        h.b_wait(3);
        chkf(fb, 4'h8, 4'h8, "B empty rise");
        e = b_data_o;
        for (int k = 0; k < 4; k++)
        begin
          h.b_op(1'b0, 1'b0, 2'h1, 2'(sw), 1'(big), ~w);
          e = big ? {lane(w, 2'(sw), k), e[26:0]} : {e[35:9], lane(w, 2'(sw), 3 - k)};
          chk(b_data_o, e, "byte read");
          chkf(fb, (k == 3) ? 4'h0 : 4'h8, 4'hC, "B empty on bytes");
        end
      end
  endtask : t_bytes

  task automatic t_long;
    logic [35:0] w;
    for (int sw = 0; sw < 4; sw++)
    begin
      w = 36'h1_2345_6789 + 36'(sw);
      h.b_op(1'b1, 1'b0, 2'h0, 2'(sw), 1'b0, swp(w, 2'(sw)));
      h.a_wait(3);
      chkf(fa, 4'h8, 4'h8, "A empty rise");
      h.a_op(1'b0, 1'b0, 36'h0);
      chk(a_data_o, w, "long write");
      h.a_op(1'b1, 1'b0, w);
      h.b_wait(3);
      h.b_op(1'b0, 1'b0, 2'h0, 2'(sw), 1'b0, 36'h0);
      chk(b_data_o, swp(w, 2'(sw)), "long read");
    end
  endtask : t_long

  task automatic t_fill_a;
    for (int i = 0; i < 33; i++)
      h.a_op(1'b1, 1'b0, 36'(i));
    chkf(fa, 4'h0, 4'h3, "A full");
    h.b_wait(3);
    chkf(fb, 4'hC, 4'hC, "B not empty");
    for (int i = 0; i < 32; i++)
    begin
      h.b_op(1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 36'h0);
      chk(b_data_o, 36'(i), "FIFO1 order");
      chkf(fb, (i < 23) ? 4'h4 : 4'h0, 4'h4, "B almost empty");
      if (i < 9)
      begin
        h.a_wait(3);
        chkf(fa, (i == 8) ? 4'h3 : 4'h2, 4'h3, "A full release");
      end
    end
    chkf(fb, 4'h0, 4'h8, "B empty, extra write dropped");
  endtask : t_fill_a

  task automatic t_fill_b;
    logic [35:0] w;
    for (int i = 0; i < 32; i++)
    begin
      w = 36'h8_0000_0000 + 36'(i);
      h.b_op(1'b1, 1'b0, 2'h2, 2'h0, 1'b1, {w[35:18], 18'h0});
      if (i == 0)
      begin
        h.a_wait(3);
        chkf(fa, 4'h0, 4'h8, "A empty after half");
      end
      chkf(fb, 4'h2, 4'h2, "B full before last");
      h.b_op(1'b1, 1'b0, 2'h2, 2'h0, 1'b1, {w[17:0], 18'h3FFFF});
      if (i == 7 || i == 8)
      begin
        h.a_wait(3);
        chkf(fa, (i == 8) ? 4'h4 : 4'h0, 4'h4, "A almost empty");
      end
    end
    chkf(fb, 4'h0, 4'h3, "B full");
    for (int i = 0; i < 32; i++)
    begin
      h.a_op(1'b0, 1'b0, 36'h0);
      chk(a_data_o, 36'h8_0000_0000 + 36'(i), "FIFO2 order");
      if (i < 9)
      begin
        h.b_wait(3);
        chkf(fb, (i == 8) ? 4'h3 : 4'h2, 4'h3, "B full release");
      end
    end
  endtask : t_fill_b

  // Byte writes, mailbox selects on port B, word reads in both endian modes
  task automatic t_narrow;
    logic [35:0] w;
    logic [35:0] e;
    logic [17:0] hw;
    for (int big = 0; big < 2; big++)
      for (int sw = 0; sw < 4; sw++)
      begin
        w = 36'h9_8765_4321 + 36'(sw * 2 + big);
        for (int k = 0; k < 4; k++)
        begin
          e[8:0] = lane(w, 2'(sw), big ? k : 3 - k);
          h.b_op(1'b1, 1'b0, 2'h1, 2'(sw), 1'(big), big ? {e[8:0], ~w[26:0]} : {~w[35:9], e[8:0]});
        end
        h.b_op(1'b1, 1'b0, 2'h3, 2'(sw), 1'(big), ~w);
        h.b_op(1'b1, 1'b1, 2'h0, 2'(sw), 1'(big), ~w);
        h.a_wait(3);
        h.a_op(1'b0, 1'b0, 36'h0);
        chk(a_data_o, w, "byte write");
        chkf(fa, 4'h0, 4'h8, "mailbox writes kept out");
        h.a_op(1'b1, 1'b0, w);
        h.b_wait(3);
        e = b_data_o;
        h.b_op(1'b0, 1'b0, 2'h3, 2'(sw), 1'(big), ~w);
        h.b_op(1'b0, 1'b1, 2'h0, 2'(sw), 1'(big), ~w);
        chk(b_data_o, e, "mailbox reads");
        chkf(fb, 4'h8, 4'h8, "FIFO1 kept");
        for (int k = 0; k < 2; k++)
        begin
          h.b_op(1'b0, 1'b0, 2'h2, 2'(sw), 1'(big), ~w);
          hw = big ? {lane(w, 2'(sw), 2 * k), lane(w, 2'(sw), 2 * k + 1)}
                   : {lane(w, 2'(sw), 2 - 2 * k), lane(w, 2'(sw), 3 - 2 * k)};
          e = big ? {hw, e[17:0]} : {e[35:18], hw};
          chk(b_data_o, e, "word read");
          chkf(fb, (k == 1) ? 4'h0 : 4'h8, 4'hC, "B empty on words");
        end
      end
  endtask : t_narrow

  ////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_reset();
    t_bytes();
    t_long();
    t_fill_a();
    t_fill_b();
    t_narrow();
    stop_test();
  end
endmodule : bfs_top_test
